//--- hw/crf_regfile.v
// Chosen here: the plain strobed port and the address map.
`include "crf_consts.vh"

module crf_regfile (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire [4:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] rdata_reg,
	input wire flag_we,
	input wire [1:0] flag_size,
	input wire [31:0] alu_result,
	input wire alu_carry,
	input wire alu_overflow,
	input wire pc_load,
	input wire [19:0] pc_target,
	input wire pc_step_en,
	input wire [2:0] pc_step,
	input wire irq_pending,
	input wire [2:0] irq_level,
	input wire irq_ack,
	input wire swi_exec,
	input wire [5:0] swi_num,
	output wire irq_accept,
	output wire [19:0] pc_out,
	output wire [19:0] vector_base_out,
	output wire [15:0] stack_pointer,
	output wire [31:0] address_pair,
	output wire [15:0] frame_base_out,
	output wire [15:0] static_base_out,
	output wire [10:0] flags_out
);

// ----------------------------------------
// helper functions
// ----------------------------------------
// flat index of a banked register: bank times seven plus slot
function [3:0] bank_idx;
	input bnk;
	input [2:0] slot;
	begin
		bank_idx = (bnk ? `CRF_BANK_SIZE : 4'h0) + {1'b0, slot};
	end
endfunction

function res_zero;
	input [1:0] size;
	input [31:0] val;
	begin
		case (size)
			`CRF_SIZE_BYTE: res_zero = (val[7:0] == 8'h00);
			`CRF_SIZE_WORD: res_zero = (val[15:0] == 16'h0000);
			default: res_zero = (val == 32'h00000000);
		endcase
	end
endfunction

function res_sign;
	input [1:0] size;
	input [31:0] val;
	begin
		case (size)
			`CRF_SIZE_BYTE: res_sign = val[7];
			`CRF_SIZE_WORD: res_sign = val[15];
			default: res_sign = val[31];
		endcase
	end
endfunction

// slots of the visible bank that a software index touches
function slot_hit;
	input [4:0] addr;
	input [2:0] slot;
	begin
		case (addr)
			`CRF_IDX_DATA0: slot_hit = (slot == 3'h0);
			`CRF_IDX_DATA1: slot_hit = (slot == 3'h1);
			`CRF_IDX_DATA2: slot_hit = (slot == 3'h2);
			`CRF_IDX_DATA3: slot_hit = (slot == 3'h3);
			`CRF_IDX_ADDR0: slot_hit = (slot == 3'h4);
			`CRF_IDX_ADDR1: slot_hit = (slot == 3'h5);
			`CRF_IDX_FB: slot_hit = (slot == 3'h6);
			`CRF_IDX_D0_HI: slot_hit = (slot == 3'h0);
			`CRF_IDX_D0_LO: slot_hit = (slot == 3'h0);
			`CRF_IDX_D1_HI: slot_hit = (slot == 3'h1);
			`CRF_IDX_D1_LO: slot_hit = (slot == 3'h1);
			`CRF_IDX_PAIR_LO: slot_hit = (slot == 3'h0) || (slot == 3'h2);
			`CRF_IDX_PAIR_HI: slot_hit = (slot == 3'h1) || (slot == 3'h3);
			`CRF_IDX_ADDR_PAIR: slot_hit = (slot == 3'h4) || (slot == 3'h5);
			default: slot_hit = 1'b0;
		endcase
	end
endfunction

// new contents of a touched slot; a byte write keeps the other byte
function [15:0] slot_merge;
	input [4:0] addr;
	input [2:0] slot;
	input [15:0] old;
	input [31:0] wdata;
	begin
		case (addr)
			`CRF_IDX_D0_HI, `CRF_IDX_D1_HI: slot_merge = {wdata[7:0], old[7:0]};
			`CRF_IDX_D0_LO, `CRF_IDX_D1_LO: slot_merge = {old[15:8], wdata[7:0]};
			// in a pair the third, fourth and second address slots take the upper word
			`CRF_IDX_PAIR_LO, `CRF_IDX_PAIR_HI, `CRF_IDX_ADDR_PAIR: begin
				if (slot == 3'h2 || slot == 3'h3 || slot == 3'h5) begin
					slot_merge = wdata[31:16];
				end else begin
					slot_merge = wdata[15:0];
				end
			end
			default: slot_merge = wdata[15:0];
		endcase
	end
endfunction

// ----------------------------------------
// storage
// ----------------------------------------
// slots 0-3 data, 4-5 address, 6 frame base; two banks of seven
reg [15:0] bank_reg [0:13];
reg [19:0] vtb_reg;
reg [19:0] pc_reg;
reg [15:0] usp_reg;
reg [15:0] isp_reg;
reg [15:0] sb_reg;
reg [10:0] flg_reg;

wire bank_sel;
wire stack_sel;
wire [2:0] processor_priority_level;
wire swi_low;
integer i;
integer s;

assign bank_sel = flg_reg[`CRF_FLG_B];
assign stack_sel = flg_reg[`CRF_FLG_U];
assign processor_priority_level = flg_reg[`CRF_FLG_IPL_MSB:`CRF_FLG_IPL_LSB];
assign swi_low = swi_exec && (swi_num < `CRF_SWI_LIMIT);

// ----------------------------------------
// views toward the datapath
// ----------------------------------------
// bank 0 when the select flag is 0, bank 1 when it is 1
wire [15:0] cur_d0 = bank_reg[bank_idx(bank_sel, 3'h0)];
wire [15:0] cur_d1 = bank_reg[bank_idx(bank_sel, 3'h1)];
wire [15:0] cur_d2 = bank_reg[bank_idx(bank_sel, 3'h2)];
wire [15:0] cur_d3 = bank_reg[bank_idx(bank_sel, 3'h3)];
wire [15:0] cur_a0 = bank_reg[bank_idx(bank_sel, 3'h4)];
wire [15:0] cur_a1 = bank_reg[bank_idx(bank_sel, 3'h5)];
wire [15:0] cur_fb = bank_reg[bank_idx(bank_sel, 3'h6)];

assign pc_out = pc_reg;
assign vector_base_out = vtb_reg;
assign stack_pointer = stack_sel ? usp_reg : isp_reg;
assign address_pair = {cur_a1, cur_a0};
assign frame_base_out = cur_fb;
assign static_base_out = sb_reg;
assign flags_out = flg_reg;
// maskable request passes only when enabled and strictly above the level
assign irq_accept = irq_pending && flg_reg[`CRF_FLG_I] && (irq_level > processor_priority_level);

// ----------------------------------------
// read path
// ----------------------------------------
reg [31:0] rdata_next;

always @* begin
	case (reg_addr)
		`CRF_IDX_DATA0: rdata_next = {16'h0000, cur_d0};
		`CRF_IDX_DATA1: rdata_next = {16'h0000, cur_d1};
		`CRF_IDX_DATA2: rdata_next = {16'h0000, cur_d2};
		`CRF_IDX_DATA3: rdata_next = {16'h0000, cur_d3};
		`CRF_IDX_ADDR0: rdata_next = {16'h0000, cur_a0};
		`CRF_IDX_ADDR1: rdata_next = {16'h0000, cur_a1};
		`CRF_IDX_FB: rdata_next = {16'h0000, cur_fb};
		`CRF_IDX_VTB: rdata_next = {12'h000, vtb_reg};
		`CRF_IDX_PC: rdata_next = {12'h000, pc_reg};
		`CRF_IDX_USP: rdata_next = {16'h0000, usp_reg};
		`CRF_IDX_ISP: rdata_next = {16'h0000, isp_reg};
		`CRF_IDX_SB: rdata_next = {16'h0000, sb_reg};
		`CRF_IDX_FLAGS: rdata_next = {21'h000000, flg_reg};
		`CRF_IDX_SP: rdata_next = {16'h0000, stack_pointer};
		`CRF_IDX_D0_HI: rdata_next = {24'h000000, cur_d0[15:8]};
		`CRF_IDX_D0_LO: rdata_next = {24'h000000, cur_d0[7:0]};
		`CRF_IDX_D1_HI: rdata_next = {24'h000000, cur_d1[15:8]};
		`CRF_IDX_D1_LO: rdata_next = {24'h000000, cur_d1[7:0]};
		`CRF_IDX_PAIR_LO: rdata_next = {cur_d2, cur_d0};
		`CRF_IDX_PAIR_HI: rdata_next = {cur_d3, cur_d1};
		`CRF_IDX_ADDR_PAIR: rdata_next = address_pair;
		default: rdata_next = 32'h00000000;
	endcase
end

// read data stand after an enabled strobe until the next clock with ce high reloads them, or clears them if the strobe is low
always @(posedge ref_clk) begin
	if (rst) begin
		rdata_reg <= 32'h00000000;
	end else if (ce) begin
		if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end
end

// ----------------------------------------
// program counter next state
// ----------------------------------------
reg [19:0] pc_next;

// a software write to the counter beats the sequencer
always @* begin
	pc_next = pc_reg;
	if (pc_load) begin
		pc_next = pc_target;
	end else if (pc_step_en) begin
		pc_next = pc_reg + {17'h00000, pc_step};
	end
	if (reg_wr && (reg_addr == `CRF_IDX_PC)) begin
		pc_next = reg_wdata[19:0];
	end
end

// ----------------------------------------
// stack pointers and base registers next state
// ----------------------------------------
reg [15:0] usp_next;
reg [15:0] isp_next;
reg [19:0] vtb_next;
reg [15:0] sb_next;

always @* begin
	usp_next = usp_reg;
	isp_next = isp_reg;
	vtb_next = vtb_reg;
	sb_next = sb_reg;
	if (reg_wr) begin
		case (reg_addr)
			`CRF_IDX_VTB: vtb_next = reg_wdata[19:0];
			`CRF_IDX_USP: usp_next = reg_wdata[15:0];
			`CRF_IDX_ISP: isp_next = reg_wdata[15:0];
			`CRF_IDX_SB: sb_next = reg_wdata[15:0];
			// the window onto the active pointer follows the stack-select flag
			`CRF_IDX_SP: begin
				if (stack_sel) begin
					usp_next = reg_wdata[15:0];
				end else begin
					isp_next = reg_wdata[15:0];
				end
			end
			default: begin
			end
		endcase
	end
end

// ----------------------------------------
// flag register next state
// ----------------------------------------
reg [10:0] flg_next;

// later assignments win: datapath, then software, then interrupt clears
always @* begin
	flg_next = flg_reg;
	// condition flags from the last operation
	if (flag_we) begin
		flg_next[`CRF_FLG_C] = alu_carry;
		flg_next[`CRF_FLG_Z] = res_zero(flag_size, alu_result);
		flg_next[`CRF_FLG_S] = res_sign(flag_size, alu_result);
		flg_next[`CRF_FLG_O] = alu_overflow;
	end
	// the debug bit is stored as written; software keeps it at zero
	if (reg_wr && (reg_addr == `CRF_IDX_FLAGS)) begin
		flg_next = reg_wdata[10:0];
	end
	// interrupt entry clears enable and stack select, winning over software
	if (irq_ack) begin
		flg_next[`CRF_FLG_I] = 1'b0;
		flg_next[`CRF_FLG_U] = 1'b0;
	end
	if (swi_low) begin
		flg_next[`CRF_FLG_U] = 1'b0;
	end
end

// ----------------------------------------
// state update
// ----------------------------------------
always @(posedge ref_clk) begin
	if (rst) begin
		for (i = 0; i < 14; i = i + 1) begin
			bank_reg[i] <= `CRF_RST_WORD;
		end
		vtb_reg <= `CRF_RST_ADDR20;
		pc_reg <= `CRF_RST_ADDR20;
		usp_reg <= `CRF_RST_WORD;
		isp_reg <= `CRF_RST_WORD;
		sb_reg <= `CRF_RST_WORD;
		flg_reg <= `CRF_RST_FLAGS;
	end else if (ce) begin
		// software writes to the visible bank land at the end of this cycle
		if (reg_wr) begin
			for (s = 0; s < 7; s = s + 1) begin
				if (slot_hit(reg_addr, s[2:0])) begin
					bank_reg[bank_idx(bank_sel, s[2:0])] <=
						slot_merge(reg_addr, s[2:0],
							bank_reg[bank_idx(bank_sel, s[2:0])], reg_wdata);
				end
			end
		end
		vtb_reg <= vtb_next;
		pc_reg <= pc_next;
		usp_reg <= usp_next;
		isp_reg <= isp_next;
		sb_reg <= sb_next;
		flg_reg <= flg_next;
	end
end

endmodule

//--- hw/crf_consts.vh
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

// ----------------------------------------
// register indices on the software port
// ----------------------------------------
`define CRF_IDX_DATA0 5'h00
`define CRF_IDX_DATA1 5'h01
`define CRF_IDX_DATA2 5'h02
`define CRF_IDX_DATA3 5'h03
`define CRF_IDX_ADDR0 5'h04
`define CRF_IDX_ADDR1 5'h05
`define CRF_IDX_FB 5'h06
`define CRF_IDX_VTB 5'h07
`define CRF_IDX_PC 5'h08
`define CRF_IDX_USP 5'h09
`define CRF_IDX_ISP 5'h0a
`define CRF_IDX_SB 5'h0b
`define CRF_IDX_FLAGS 5'h0c
`define CRF_IDX_SP 5'h0d
`define CRF_IDX_D0_HI 5'h0e
`define CRF_IDX_D0_LO 5'h0f
`define CRF_IDX_D1_HI 5'h10
`define CRF_IDX_D1_LO 5'h11
`define CRF_IDX_PAIR_LO 5'h12
`define CRF_IDX_PAIR_HI 5'h13
`define CRF_IDX_ADDR_PAIR 5'h14

// ----------------------------------------
// flag register field positions
// ----------------------------------------
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7
`define CRF_FLG_IPL_LSB 8
`define CRF_FLG_IPL_MSB 10

// ----------------------------------------
// reset values and other constants
// ----------------------------------------
`define CRF_RST_WORD 16'h0000
`define CRF_RST_ADDR20 20'h00000
`define CRF_RST_FLAGS 11'h000
`define CRF_BANK_SIZE 4'h7
`define CRF_SWI_LIMIT 6'h20
`define CRF_SIZE_BYTE 2'h0
`define CRF_SIZE_WORD 2'h1
`define CRF_SIZE_LONG 2'h2

`endif

//--- dv/crf_regfile_sva.sv
`include "crf_consts.vh"
module crf_regfile_sva (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] rdata_reg,
	input wire flag_we,
	input wire [1:0] flag_size,
	input wire [31:0] alu_result,
	input wire alu_carry,
	input wire alu_overflow,
	input wire pc_load,
	input wire [19:0] pc_target,
	input wire pc_step_en,
	input wire [2:0] pc_step,
	input wire irq_pending,
	input wire [2:0] irq_level,
	input wire irq_ack,
	input wire swi_exec,
	input wire [5:0] swi_num,
	input wire irq_accept,
	input wire [19:0] pc_out,
	input wire [10:0] flags_out
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// a software write to the flags or pc overrides the datapath update
	wire fw = ce && flag_we && flag_size == 2'h1 && !(reg_wr && reg_addr == `CRF_IDX_FLAGS);
	wire pw = reg_wr && reg_addr == `CRF_IDX_PC;
	rd_idle_zero_a: assert property (ce && !reg_rd |=> rdata_reg == 32'h0)
		else $error("read data not idle");
	zero_flag_a: assert property (fw |=> flags_out[2] == ($past(alu_result[15:0]) == 16'h0))
		else $error("zero flag wrong");
	sign_flag_a: assert property (fw |=> flags_out[3] == $past(alu_result[15]))
		else $error("sign flag wrong");
	carry_flag_a: assert property (fw |=> flags_out[0] == $past(alu_carry))
		else $error("carry flag wrong");
	ovf_flag_a: assert property (fw |=> flags_out[5] == $past(alu_overflow))
		else $error("overflow flag wrong");
	ack_clear_a: assert property (ce && irq_ack |=> flags_out[7:6] == 2'h0)
		else $error("ack did not clear flags");
	swi_clear_a: assert property (ce && swi_exec && swi_num < 6'h20 |=> !flags_out[7])
		else $error("soft interrupt kept stack select");
	accept_level_a: assert property (irq_accept == (irq_pending && flags_out[6]
		&& irq_level > flags_out[10:8]))
		else $error("accept wrong");
	pc_load_a: assert property (ce && pc_load && !pw |=> pc_out == $past(pc_target))
		else $error("pc load wrong");
	pc_step_a: assert property (ce && pc_step_en && !pc_load && !pw
		|=> pc_out == $past(pc_out) + $past(pc_step))
		else $error("pc step wrong");
	cover property (irq_accept);
	cover property (fw ##1 flags_out[2]);
	cover property (ce && swi_exec ##1 flags_out[7]);
endmodule
bind crf_regfile crf_regfile_sva u_sva (.*);

//--- dv/crf_dp_model.sv
module crf_dp_model (
	input wire ref_clk,
	input wire go,
	input wire [15:0] op_a,
	input wire [15:0] op_b,
	output logic flag_we,
	output logic [31:0] alu_result,
	output logic alu_carry,
	output logic alu_overflow
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// word adder; idle outputs toggle so stale values never pass
	// ----------------------------------------
	logic [16:0] sum;
	initial begin
		flag_we = 0;
		alu_result = 0;
		alu_carry = 0;
		alu_overflow = 0;
	end
	always @(posedge ref_clk) begin
		sum = op_a + op_b;
		flag_we <= go;
		alu_result <= go ? {16'h0, sum[15:0]} : ~alu_result;
		alu_carry <= go ? sum[16] : ~alu_carry;
		alu_overflow <= go ? (op_a[15] == op_b[15] && sum[15] != op_a[15]) : ~alu_overflow;
	end
endmodule

//--- dv/crf_regfile_bench.sv
`include "crf_consts.vh"
module crf_regfile_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, go = 0;
	logic pc_load = 0, pc_step_en = 0, irq_pending = 0, irq_ack = 0, swi_exec = 0;
	logic flag_we, alu_carry, alu_overflow, irq_accept;
	logic [4:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, rdata_reg, alu_result, address_pair, v;
	logic [1:0] flag_size = 1;
	logic [19:0] pc_target = 0, pc_out, vector_base_out;
	logic [2:0] pc_step = 0, irq_level = 0;
	logic [5:0] swi_num = 0;
	logic [15:0] op_a = 0, op_b = 0, stack_pointer, frame_base_out, static_base_out;
	logic [15:0] ta[4] = '{16'hffff, 16'h7fff, 16'h0001, 16'h00ff};
	logic [15:0] tb[4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001};
	logic [5:0] te[4] = '{6'h05, 6'h28, 6'h00, 6'h04};
	logic [1:0] ts[4] = '{2'h1, 2'h1, 2'h1, 2'h0};
	logic [10:0] flags_out;
	int error_cnt = 0, tests_run = 0;
	crf_regfile u_dut (.*);
	crf_dp_model u_model (.*);
	initial forever #2.5 ref_clk = ~ref_clk;
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
		#1;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 chk(rdata_reg, e);
	endtask
	task give_verdict;
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		rd(`CRF_IDX_FLAGS, 0);
		for (int i = 0; i < 12; i++) begin
			v = 32'hfedcba98 ^ i;
			wr(i[4:0], v);
			rd(i[4:0], v & ((i == 7 || i == 8) ? 32'hfffff : 32'hffff));
		end
		chk(vector_base_out, 32'hcba9f);
		chk(static_base_out, 32'hba93);
		wr(`CRF_IDX_DATA0, 32'h1234);
		wr(`CRF_IDX_D0_HI, 32'hab);
		rd(`CRF_IDX_DATA0, 32'hab34);
		wr(`CRF_IDX_D1_LO, 32'hcd);
		rd(`CRF_IDX_DATA1, 32'hbacd);
		wr(`CRF_IDX_PAIR_LO, 32'h11112222);
		rd(`CRF_IDX_DATA2, 32'h1111);
		wr(`CRF_IDX_PAIR_HI, 32'h33334444);
		rd(`CRF_IDX_DATA3, 32'h3333);
		wr(`CRF_IDX_ADDR_PAIR, 32'h55556666);
		rd(`CRF_IDX_ADDR1, 32'h5555);
		chk(address_pair, 32'h55556666);
		wr(`CRF_IDX_FLAGS, 32'h010);
		wr(`CRF_IDX_DATA0, 32'h0bbb);
		wr(`CRF_IDX_FB, 32'h0fbf);
		chk(frame_base_out, 32'h0fbf);
		rd(`CRF_IDX_DATA0, 32'h0bbb);
		wr(`CRF_IDX_FLAGS, 32'h000);
		rd(`CRF_IDX_DATA0, 32'h2222);
		chk(frame_base_out, 32'hba9e);
		chk(stack_pointer, 32'hba92);
		wr(`CRF_IDX_FLAGS, 32'h0c0);
		rd(`CRF_IDX_SP, 32'hba91);
		@(posedge ref_clk);
		irq_ack <= 1;
		@(posedge ref_clk);
		irq_ack <= 0;
		#1 chk(flags_out, 11'h000);
		chk(stack_pointer, 32'hba92);
		wr(`CRF_IDX_FLAGS, 32'h080);
		for (int n = 32; n >= 31; n--) begin
			@(posedge ref_clk);
			swi_exec <= 1;
			swi_num <= n[5:0];
			@(posedge ref_clk);
			swi_exec <= 0;
			#1 chk(flags_out[7], n == 32);
		end
		wr(`CRF_IDX_FLAGS, 32'h340);
		for (int l = 3; l < 5; l++) begin
			@(posedge ref_clk);
			irq_pending <= 1;
			irq_level <= l[2:0];
			#1 chk(irq_accept, l == 4);
		end
		wr(`CRF_IDX_FLAGS, 32'h300);
		chk(irq_accept, 0);
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			go <= 1;
			flag_size <= ts[k];
			op_a <= ta[k];
			op_b <= tb[k];
			@(posedge ref_clk);
			go <= 0;
			@(posedge ref_clk);
			#1 chk(flags_out[5:0], te[k]);
		end
		@(posedge ref_clk);
		pc_load <= 1;
		pc_target <= 20'h12345;
		@(posedge ref_clk);
		pc_load <= 0;
		pc_step_en <= 1;
		pc_step <= 3'h3;
		#1 chk(pc_out, 20'h12345);
		@(posedge ref_clk);
		pc_step_en <= 0;
		#1 chk(pc_out, 20'h12348);
		// clock enable low: a write and a step offered together must both be ignored
		@(posedge ref_clk);
		ce <= 0;
		reg_wr <= 1;
		reg_addr <= `CRF_IDX_SB;
		pc_step_en <= 1;
		@(posedge ref_clk);
		ce <= 1;
		reg_wr <= 0;
		pc_step_en <= 0;
		#1 chk(static_base_out, 32'hba93);
		chk(pc_out, 20'h12348);
		rd(5'h15, 0);
		give_verdict;
	end
endmodule
